// file: fap_alarm_check.sv
// Alarm status, alarm masking and input pattern checker registers
module fap_alarm_check #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic data_clk,
    input wire logic [7:0] data_in,
    input wire logic data_frame,
    input wire logic [FIFO_DEPTH-1:0] fifo_wr_ptr,
    input wire logic [FIFO_DEPTH-1:0] fifo_rd_ptr,
    input wire logic checker_enable,
    input wire logic good_run_autoclear_enable,
    input wire logic near_two_alarm_enable,
    input wire logic near_one_alarm_enable,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    output logic [7:0] reg_rdata,
    output logic alarm_out_pin
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] hold_data;
    logic hold_frame;
    logic hold_toggle;
    logic link_resetn;
    logic toggle_sync;
    logic toggle_seen;
    logic sample_strobe;
    logic [7:0] samp_data;
    logic samp_frame;
    logic compare_valid;
    logic [2:0] word_index;
    logic [2:0] cur_index;
    logic [7:0] expected_word;
    logic [7:0] mismatch_bits;
    logic sample_bad;
    logic [5:0] good_run;
    logic autoclear_fire;
    logic [7:0] alarm_suppress_mask;
    logic [7:0] alarm_status;
    logic [7:0] pattern_fail_lanes;
    logic [7:0] check_word_0;
    logic [7:0] check_word_1;
    logic [7:0] check_word_2;
    logic [7:0] check_word_3;
    logic [7:0] set_vec;
    logic wrptr_zero;
    logic ptr_collision;
    logic ptr_near_one;
    logic ptr_near_two;
    logic host_clear_status;
    logic host_clear_lanes;
    logic [7:0] next_alarm_status;
    logic [7:0] next_pattern_fail_lanes;
    logic [7:0] next_rdata;

    function automatic logic [FIFO_DEPTH-1:0] rot_by(
        input logic [FIFO_DEPTH-1:0] v,
        input int n
    );
        logic [FIFO_DEPTH-1:0] r;
        r = v;
        for (int k = 0; k < n; k++) begin
            r = {r[FIFO_DEPTH-2:0], r[FIFO_DEPTH-1]};
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Link domain reset
    // ------------------------------------------------------------
    // Release is retimed to the link clock so no capture flop sees reset
    // leave close to its clock edge; assertion still acts at once.
    fap_sync2 u_link_reset (
        .clk(data_clk),
        .resetn(resetn),
        .async_in(1'b1),
        .sync_out(link_resetn)
    );

    // ------------------------------------------------------------
    // Link domain capture
    // ------------------------------------------------------------
    // Each byte is held for a whole link period, far longer than the
    // synchroniser delay, so the held word is stable when it is read.
    always_ff @(posedge data_clk or negedge link_resetn) begin
        if (!link_resetn) begin
            hold_data <= 8'h00;
            hold_frame <= 1'b0;
            hold_toggle <= 1'b0;
        end else begin
            hold_data <= data_in;
            hold_frame <= data_frame;
            hold_toggle <= ~hold_toggle;
        end
    end

    fap_sync2 u_toggle_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in(hold_toggle),
        .sync_out(toggle_sync)
    );

    // ------------------------------------------------------------
    // Sample strobe in the converter domain
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            toggle_seen <= 1'b0;
        end else begin
            toggle_seen <= toggle_sync;
        end
    end

    assign sample_strobe = toggle_sync ^ toggle_seen;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            samp_data <= 8'h00;
            samp_frame <= 1'b0;
        end else if (sample_strobe) begin
            samp_data <= hold_data;
            samp_frame <= hold_frame;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            compare_valid <= 1'b0;
        end else begin
            compare_valid <= sample_strobe;
        end
    end

    // ------------------------------------------------------------
    // Pattern sequencing
    // ------------------------------------------------------------
    // A frame byte restarts the walk, so a slipped link realigns by itself
    // walk the words
    assign cur_index = samp_frame ? 3'h0 : word_index;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            word_index <= 3'h0;
        end else if (compare_valid) begin
            word_index <= cur_index + 3'h1;
        end
    end

    always_comb begin
        unique case (cur_index)
            3'h0: expected_word = check_word_0;
            3'h1: expected_word = check_word_1;
            3'h2: expected_word = check_word_2;
            3'h3: expected_word = check_word_3;
            3'h4: expected_word = fap_pkg::FIXED_CHECK_WORD_4;
            3'h5: expected_word = fap_pkg::FIXED_CHECK_WORD_5;
            3'h6: expected_word = fap_pkg::FIXED_CHECK_WORD_6;
            3'h7: expected_word = fap_pkg::FIXED_CHECK_WORD_7;
        endcase
    end

    assign mismatch_bits = samp_data ^ expected_word;

    assign sample_bad = compare_valid & checker_enable & (|mismatch_bits);

    // ------------------------------------------------------------
    // Good-run auto-clear
    // ------------------------------------------------------------
    // Count wraps after firing, so a long clean run clears again every 64
    // count good samples
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            good_run <= 6'h00;
        end else if (!good_run_autoclear_enable || !checker_enable) begin
            good_run <= 6'h00;
        end else if (compare_valid) begin
            if (|mismatch_bits) begin
                good_run <= 6'h00;
            end else begin
                good_run <= good_run + 6'h01;
            end
        end
    end

    assign autoclear_fire = good_run_autoclear_enable & checker_enable & compare_valid
        & ~(|mismatch_bits) & (good_run == fap_pkg::GOOD_RUN_LAST);

    // ------------------------------------------------------------
    // FIFO pointer conditions
    // ------------------------------------------------------------
    // all-zero write pointer
    // zero pointer stays flagged every cycle
    assign wrptr_zero = (fifo_wr_ptr == '0);
    assign ptr_collision = |(fifo_wr_ptr & fifo_rd_ptr);
    assign ptr_near_one = |(fifo_wr_ptr & rot_by(fifo_rd_ptr, 1))
        | |(fifo_rd_ptr & rot_by(fifo_wr_ptr, 1));
    assign ptr_near_two = |(fifo_wr_ptr & rot_by(fifo_rd_ptr, 2))
        | |(fifo_rd_ptr & rot_by(fifo_wr_ptr, 2));

    // Pointer flags follow the pointers; only the stored status bit is sticky
    always_comb begin
        set_vec = 8'h00;
        set_vec[fap_pkg::BIT_WRPTR_ZERO] = wrptr_zero;
        set_vec[fap_pkg::BIT_FIFO_COLLISION] = ptr_collision;
        set_vec[fap_pkg::BIT_PATTERN_MISMATCH] = sample_bad;
        set_vec[fap_pkg::BIT_NEAR_TWO] = ptr_near_two & near_two_alarm_enable;
        set_vec[fap_pkg::BIT_NEAR_ONE] = ptr_near_one & near_one_alarm_enable;
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    assign host_clear_status = reg_wr & (reg_addr == fap_pkg::OFS_ALARM_STATUS);
    assign host_clear_lanes = reg_wr & (reg_addr == fap_pkg::OFS_PATTERN_FAIL_LANES);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alarm_suppress_mask <= fap_pkg::RST_ALARM_SUPPRESS_MASK;
        end else if (reg_wr && reg_addr == fap_pkg::OFS_ALARM_SUPPRESS_MASK) begin
            alarm_suppress_mask <= reg_wdata & fap_pkg::ALARM_USED_BITS;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            check_word_0 <= fap_pkg::RST_CHECK_WORD_0;
            check_word_1 <= fap_pkg::RST_CHECK_WORD_1;
            check_word_2 <= fap_pkg::RST_CHECK_WORD_2;
            check_word_3 <= fap_pkg::RST_CHECK_WORD_3;
        end else if (reg_wr) begin
            if (reg_addr == fap_pkg::OFS_CHECK_WORD_0) begin
                check_word_0 <= reg_wdata;
            end
            if (reg_addr == fap_pkg::OFS_CHECK_WORD_1) begin
                check_word_1 <= reg_wdata;
            end
            if (reg_addr == fap_pkg::OFS_CHECK_WORD_2) begin
                check_word_2 <= reg_wdata;
            end
            if (reg_addr == fap_pkg::OFS_CHECK_WORD_3) begin
                check_word_3 <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Sticky status and failure map
    // ------------------------------------------------------------
    // write clears status
    always_comb begin
        next_alarm_status = alarm_status;
        if (host_clear_status || autoclear_fire) begin
            next_alarm_status = 8'h00;
        end
        next_alarm_status = (next_alarm_status | set_vec) & fap_pkg::ALARM_USED_BITS;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alarm_status <= fap_pkg::RST_ALARM_STATUS;
        end else begin
            alarm_status <= next_alarm_status;
        end
    end

    always_comb begin
        next_pattern_fail_lanes = pattern_fail_lanes;
        if (host_clear_lanes || autoclear_fire) begin
            next_pattern_fail_lanes = 8'h00;
        end
        if (sample_bad) begin
            next_pattern_fail_lanes = next_pattern_fail_lanes | mismatch_bits;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pattern_fail_lanes <= fap_pkg::RST_PATTERN_FAIL_LANES;
        end else begin
            pattern_fail_lanes <= next_pattern_fail_lanes;
        end
    end

    // ------------------------------------------------------------
    // Alarm pin
    // ------------------------------------------------------------
    // Registered so the pin cannot glitch while status and mask settle
    // suppressed alarms blocked
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alarm_out_pin <= 1'b0;
        end else begin
            alarm_out_pin <= |(alarm_status & ~alarm_suppress_mask);
        end
    end

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    // Unmapped offsets read zero so software never sees stale data
    always_comb begin
        unique case (reg_addr)
            fap_pkg::OFS_ALARM_SUPPRESS_MASK: next_rdata = alarm_suppress_mask;
            fap_pkg::OFS_ALARM_STATUS: next_rdata = alarm_status;
            fap_pkg::OFS_PATTERN_FAIL_LANES: next_rdata = pattern_fail_lanes;
            fap_pkg::OFS_CHECK_WORD_0: next_rdata = check_word_0;
            fap_pkg::OFS_CHECK_WORD_1: next_rdata = check_word_1;
            fap_pkg::OFS_CHECK_WORD_2: next_rdata = check_word_2;
            fap_pkg::OFS_CHECK_WORD_3: next_rdata = check_word_3;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule

// file: fap_pkg.sv
// Constants shared by the alarm and pattern check block
// Function
// - A suppressed alarm never drives the alarm output pin.
// - Suppress bit 0 unmasks, 1 masks; bits align with status flags.
// - Status bit 6 sets while the FIFO write pointer is all zeros.
// - Write pointer is one-hot; all zeros stalls it until next sync.
// - Status bit 5 sets when FIFO pointers overrun or underrun each other.
// - Status bit 3 sets when an input byte differs from its check word.
// - Status bit 1 sets when FIFO pointers are within two addresses.
// - Status bit 0 sets when FIFO pointers are within one address.
// - Alarm status resets to zero and a host write clears it.
// - An 8-bit failure map records mismatching lanes; write clears, resets zero.
// - Eight 8-bit check words are compared in sequence with input data.
// - Check words zero, one and two reset to their printed defaults.
// - Check word three resets to 0x45.
// - Pattern comparison and mismatch reporting work only with checker enabled.
// - With auto-clear on, 64 consecutive good samples clear the alarms.
// - The two-apart FIFO alarm needs its own enable bit.
// - The one-apart FIFO alarm needs its own enable bit.
package fap_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_ALARM_SUPPRESS_MASK = 5'h06;
    localparam logic [4:0] OFS_ALARM_STATUS = 5'h07;
    localparam logic [4:0] OFS_PATTERN_FAIL_LANES = 5'h08;
    localparam logic [4:0] OFS_CHECK_WORD_0 = 5'h09;
    localparam logic [4:0] OFS_CHECK_WORD_1 = 5'h0A;
    localparam logic [4:0] OFS_CHECK_WORD_2 = 5'h0B;
    localparam logic [4:0] OFS_CHECK_WORD_3 = 5'h0C;

    // ------------------------------------------------------------
    // Status bit positions
    // ------------------------------------------------------------
    localparam int BIT_WRPTR_ZERO = 6;
    localparam int BIT_FIFO_COLLISION = 5;
    localparam int BIT_PATTERN_MISMATCH = 3;
    localparam int BIT_NEAR_TWO = 1;
    localparam int BIT_NEAR_ONE = 0;
    localparam logic [7:0] ALARM_USED_BITS = 8'h6B;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ALARM_SUPPRESS_MASK = 8'h00;
    localparam logic [7:0] RST_ALARM_STATUS = 8'h00;
    localparam logic [7:0] RST_PATTERN_FAIL_LANES = 8'h00;
    localparam logic [7:0] RST_CHECK_WORD_0 = 8'h7A;
    localparam logic [7:0] RST_CHECK_WORD_1 = 8'hB6;
    localparam logic [7:0] RST_CHECK_WORD_2 = 8'hEA;
    localparam logic [7:0] RST_CHECK_WORD_3 = 8'h45;
    // Words four to seven are not writable in this block
    localparam logic [7:0] FIXED_CHECK_WORD_4 = 8'h1A;
    localparam logic [7:0] FIXED_CHECK_WORD_5 = 8'h16;
    localparam logic [7:0] FIXED_CHECK_WORD_6 = 8'hAA;
    localparam logic [7:0] FIXED_CHECK_WORD_7 = 8'hC6;

    // ------------------------------------------------------------
    // Counts
    // ------------------------------------------------------------
    localparam int PATTERN_WORDS = 8;
    localparam logic [5:0] GOOD_RUN_LAST = 6'h3F;

endpackage

// file: fap_sync2.sv
// Two-flop level synchroniser
module fap_sync2 (
    input wire logic clk,
    input wire logic resetn,
    input wire logic async_in,
    output logic sync_out
);
    logic stage1;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage1 <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// file: fap_src.sv
// Link source model streaming the check pattern
module fap_src (
    output logic data_clk,
    output logic [7:0] data_in,
    output logic data_frame,
    input wire logic [7:0] err_xor
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] idx = 3'h0;
    logic [7:0] byte_q = 8'h00;
    logic frame_q = 1'b0;
    logic [7:0] pat [8] = '{8'h7A, 8'hB6, 8'hEA, 8'h45, 8'h1A, 8'h16, 8'hAA, 8'hC6};
    assign data_in = byte_q;
    assign data_frame = frame_q;
    // Free-running link clock; odd offset keeps it unrelated to clk
    initial begin
        data_clk = 1'b0;
        #17;
        forever #62.5 data_clk = ~data_clk;
    end
    always @(negedge data_clk) begin
        byte_q <= pat[idx] ^ (idx == 3'h2 ? err_xor : 8'h00);
        frame_q <= idx == 3'h0;
        idx <= idx + 3'h1;
    end
endmodule

// file: fap_alarm_check_chk.sv
// Port-level checks of the alarm and pattern check block
module fap_alarm_check_chk #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [FIFO_DEPTH-1:0] fifo_wr_ptr,
    input wire logic [FIFO_DEPTH-1:0] fifo_rd_ptr,
    input wire logic checker_enable,
    input wire logic good_run_autoclear_enable,
    input wire logic near_two_alarm_enable,
    input wire logic near_one_alarm_enable,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic [7:0] reg_rdata,
    input wire logic alarm_out_pin
);
    logic [7:0] mask_sh;
    logic quiet;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Mask shadow; only writable bits are kept
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mask_sh <= 8'h00;
        end else if (reg_wr && reg_addr == 5'h06) begin
            mask_sh <= reg_wdata & 8'h6B;
        end
    end
    assign quiet = !checker_enable && !near_one_alarm_enable && !near_two_alarm_enable
        && fifo_wr_ptr != '0 && (fifo_wr_ptr & fifo_rd_ptr) == '0;
    property p_unmapped;
        !(reg_addr inside {[5'h06:5'h0C]}) |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_mask_rsv;
        reg_addr == 5'h06 |=> (reg_rdata & 8'h94) == 8'h00;
    endproperty
    a_mask_rsv: assert property (p_mask_rsv) else $error("mask reserved bit");
    property p_stat_rsv;
        reg_addr == 5'h07 |=> (reg_rdata & 8'h94) == 8'h00;
    endproperty
    a_stat_rsv: assert property (p_stat_rsv) else $error("status reserved bit");
    property p_wrzero;
        (fifo_wr_ptr == '0 && reg_addr == 5'h07 && !reg_wr)[*4] |-> reg_rdata[6];
    endproperty
    a_wrzero: assert property (p_wrzero) else $error("zero pointer flag");
    property p_coll;
        ((fifo_wr_ptr & fifo_rd_ptr) != '0 && reg_addr == 5'h07 && !reg_wr)[*4]
            |-> reg_rdata[5];
    endproperty
    a_coll: assert property (p_coll) else $error("collision flag");
    property p_pin_off;
        reg_addr == 5'h07 ##1 (reg_rdata & ~$past(mask_sh)) == 8'h00 |-> !alarm_out_pin;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("masked alarm on pin");
    property p_pin_on;
        (reg_addr == 5'h07 && mask_sh == 8'h00 && !reg_wr && !good_run_autoclear_enable)[*3]
            ##0 reg_rdata != 8'h00 |=> alarm_out_pin;
    endproperty
    a_pin_on: assert property (p_pin_on) else $error("unmasked alarm off");
    property p_word_rw;
        reg_wr && reg_addr == 5'h09 ##1 reg_addr == 5'h09 && !reg_wr
            |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_word_rw: assert property (p_word_rw) else $error("word readback");
    property p_clear;
        (quiet && !reg_wr) ##1 (quiet && reg_wr && reg_addr == 5'h07)
            ##1 (quiet && !reg_wr && reg_addr == 5'h07)[*2] |-> reg_rdata == 8'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("status not cleared");
    property p_lanes_off;
        (reg_addr == 5'h08 && !reg_wr && !checker_enable)[*8] |-> $stable(reg_rdata);
    endproperty
    a_lanes_off: assert property (p_lanes_off) else $error("lanes moved");
    c_clear: cover property (reg_wr && reg_addr == 5'h07);
    c_pin: cover property (alarm_out_pin);
    c_auto: cover property (checker_enable && good_run_autoclear_enable);
endmodule
bind fap_alarm_check fap_alarm_check_chk #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (
    .clk(clk), .resetn(resetn), .fifo_wr_ptr(fifo_wr_ptr), .fifo_rd_ptr(fifo_rd_ptr),
    .checker_enable(checker_enable), .good_run_autoclear_enable(good_run_autoclear_enable),
    .near_two_alarm_enable(near_two_alarm_enable),
    .near_one_alarm_enable(near_one_alarm_enable), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .alarm_out_pin(alarm_out_pin));

// file: fap_alarm_check_bench.sv
// Testbench of the alarm and pattern check block
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %0t got %h exp %h", $time, g, e); end end
module fap_alarm_check_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, resetn, dclk, frame, chk_en, ac_en, n2_en, n1_en, wr_en, alarm;
    logic [7:0] din, wp, rp, wdata, rdata, err;
    logic [4:0] addr;
    int n_fail = 0;
    int n_checks = 0;
    fap_alarm_check i_fap_alarm_check (.clk(clk), .resetn(resetn), .data_clk(dclk),
        .data_in(din), .data_frame(frame), .fifo_wr_ptr(wp), .fifo_rd_ptr(rp),
        .checker_enable(chk_en), .good_run_autoclear_enable(ac_en),
        .near_two_alarm_enable(n2_en), .near_one_alarm_enable(n1_en), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr_en), .reg_rdata(rdata), .alarm_out_pin(alarm));
    fap_src i_fap_src (.data_clk(dclk), .data_in(din), .data_frame(frame), .err_xor(err));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    // Read data trails the address by one cycle
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        cyc(2);
        #1;
        `CHK(rdata, e)
        @(posedge clk);
    endtask
    task automatic t_reset;
        logic [7:0] e [8] = '{8'h00, 8'h00, 8'h00, 8'h7A, 8'hB6, 8'hEA, 8'h45, 8'h00};
        for (int i = 0; i < 8; i++) rd(5'(6 + i), e[i]);
        $display("reset values done");
    endtask
    task automatic t_rw;
        logic [7:0] d [4] = '{8'h7A, 8'hB6, 8'hEA, 8'h45};
        wr(5'h06, 8'hFF);
        rd(5'h06, 8'h6B);
        wr(5'h06, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(5'(9 + i), 8'hA5);
            rd(5'(9 + i), 8'hA5);
            wr(5'(9 + i), d[i]);
        end
        $display("register access done");
    endtask
    task automatic t_fifo;
        logic [7:0] w [7] = '{8'h01, 8'h01, 8'h00, 8'h01, 8'h01, 8'h01, 8'h80};
        logic [7:0] r [7] = '{8'h02, 8'h01, 8'h10, 8'h02, 8'h04, 8'h04, 8'h01};
        logic [1:0] en [7] = '{2'h1, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0, 2'h1};
        logic [7:0] e [7] = '{8'h01, 8'h20, 8'h40, 8'h00, 8'h02, 8'h00, 8'h01};
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            wp <= w[i];
            rp <= r[i];
            {n2_en, n1_en} <= en[i];
            cyc(4);
            wp <= 8'h01;
            rp <= 8'h10;
            {n2_en, n1_en} <= 2'h0;
            cyc(3);
            rd(5'h07, e[i]);
            wr(5'h07, 8'h00);
            rd(5'h07, 8'h00);
        end
        $display("fifo flags done");
    endtask
    task automatic t_mask;
        wr(5'h06, 8'h40);
        wp <= 8'h00;
        cyc(4);
        #1;
        `CHK(alarm, 1'b0)
        rd(5'h07, 8'h40);
        wr(5'h06, 8'h00);
        cyc(3);
        #1;
        `CHK(alarm, 1'b1)
        @(posedge clk);
        wp <= 8'h01;
        wr(5'h07, 8'h00);
        cyc(3);
        #1;
        `CHK(alarm, 1'b0)
        @(posedge clk);
        $display("alarm mask done");
    endtask
    // Pattern errors are injected on word two only
    task automatic t_pat;
        chk_en <= 1'b1;
        cyc(200);
        wr(5'h07, 8'h00);
        wr(5'h08, 8'h00);
        cyc(200);
        rd(5'h07, 8'h00);
        err <= 8'h81;
        cyc(250);
        err <= 8'h00;
        rd(5'h07, 8'h08);
        rd(5'h08, 8'h81);
        cyc(20);
        wr(5'h07, 8'h00);
        rd(5'h07, 8'h00);
        wr(5'h08, 8'h00);
        rd(5'h08, 8'h00);
        chk_en <= 1'b0;
        err <= 8'hFF;
        cyc(250);
        rd(5'h07, 8'h00);
        rd(5'h08, 8'h00);
        chk_en <= 1'b1;
        ac_en <= 1'b1;
        err <= 8'h81;
        cyc(200);
        err <= 8'h00;
        cyc(20);
        rd(5'h07, 8'h08);
        cyc(1000);
        rd(5'h07, 8'h00);
        rd(5'h08, 8'h00);
        chk_en <= 1'b0;
        ac_en <= 1'b0;
        $display("pattern check done");
    endtask
    task automatic summarize;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Whole sequence needs about 24 us
    initial begin
        #150000;
        n_fail++;
        summarize();
    end
    initial begin
        resetn = 1'b0;
        {chk_en, ac_en, n2_en, n1_en, wr_en} = 5'h00;
        wp = 8'h01;
        rp = 8'h10;
        err = 8'h00;
        wdata = 8'h00;
        addr = 5'h00;
        cyc(3);
        resetn <= 1'b1;
        t_reset();
        t_rw();
        t_fifo();
        t_mask();
        t_pat();
        summarize();
    end
endmodule
